/* hdl/cam_unit.sv */
// instruction format decoder and effective address generator
// Summary of operation
// - instruction is a first 16-bit word plus 16-bit extension words after it
// - operation field is the top four bits; a second one follows it
// - address registers use 3-bit codes, data registers 3 or 4 bits
// - extension is 8, 16 or 32 bits; 24-bit values have top byte zero
// - addresses computed in 24 bits, low 16 bits are the effective address
// - arithmetic and logic accept only register direct, immediate and implicit
// - transfers accept all modes but pc relative, memory indirect and implicit
// - bit ops use direct, indirect or absolute; bit number from register or immediate
// - register direct picks byte, half or full 32-bit register
// - register indirect uses low 24 bits of the address register
// - displacement of 16 (sign-extended) or 24 bits added to register
// - post-increment add_constant_instruction 1, 2 or 4 by size after the access
// - pre-decrement subtracts 1, 2 or 4 first and writes the result back
// - 8-bit absolute fills upper bits with ones
// - 16-bit absolute sign-extends; 16 and 24-bit reach all 64k
// - immediate of 8, 16 or 32 bits; constant add/sub and inc/dec implicit
// - trap carries a 2-bit vector select in its opcode word
// - pc relative add_constant_instruction sign-extended 8/16-bit displacement to next pc
// - memory indirect allowed only for jump and subroutine call
// - memory indirect reads a longword at zero-extended 8-bit address
`timescale 1ns/1ps
module cam_unit
	import cam_pkg::*;
(
	input  wire logic        sys_clk,   // 20 MHz clock
	input  wire logic        rst_b,     // async reset, active low
	input  wire logic        cmdValid,  // new instruction offered
	input  wire cam_cmd_s    cmd,       // first word and its decode
	output logic             cmdReady,  // idle, takes cmd
	input  wire logic        wordValid, // extension word offered
	input  wire logic [15:0] word,      // extension word
	output logic             wordReady, // extension word taken
	output logic [2:0]       regSelA,   // address/operand register index
	input  wire logic [31:0] regDataA,  // contents of regSelA
	output logic [2:0]       regSelB,   // bit number register index
	input  wire logic [31:0] regDataB,  // contents of regSelB
	output logic             memReq,    // longword read request
	output logic [15:0]      memAddr,   // read address
	input  wire logic        memAck,    // read data valid
	input  wire logic [31:0] memData,   // read data
	output logic             resValid,  // result pulse
	output cam_result_s      res        // decoded result
);
	cam_state_s s;
	cam_state_s next_s;

	function automatic logic modeLegal(input cam_class_e c, input cam_mode_e m);
		logic ok;
		ok = 1'b0;
		unique case (c)
			CL_ARITH:   ok = (m == AM_REGDIR) || (m == AM_IMM) || (m == AM_IMPLICIT);
			CL_XFER:    ok = (m != AM_PCREL) && (m != AM_MEMIND) && (m != AM_IMPLICIT);
			CL_BIT:     ok = (m == AM_REGDIR) || (m == AM_REGIND) || (m == AM_ABS);
			CL_JUMP:    ok = (m == AM_REGIND) || (m == AM_ABS) || (m == AM_MEMIND);
			CL_RELCALL: ok = (m == AM_PCREL);
			CL_TRAP:    ok = (m == AM_IMPLICIT);
			default:    ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic [31:0] stepOf(input logic [1:0] sz);
		logic [31:0] st;
		st = STEP_LONG;
		if (sz == SZ_BYTE) begin
			st = STEP_BYTE;
		end else if (sz == SZ_WORD) begin
			st = STEP_WORD;
		end
		return st;
	endfunction

	function automatic logic [31:0] sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	function automatic logic [23:0] sext8(input logic [7:0] v);
		return {{16{v[7]}}, v};
	endfunction

	// extension widths each mode can carry; a mismatch is refused like a bad mode
	function automatic logic xwLegal(input cam_mode_e m, input cam_xw_e xw);
		logic ok;
		ok = 1'b0;
		unique case (m)
			AM_DISP:  ok = (xw == XW_16) || (xw == XW_24);
			AM_ABS:   ok = (xw != XW_32);
			AM_IMM:   ok = 1'b1;
			AM_PCREL: ok = (xw == XW_8) || (xw == XW_16);
			default:  ok = (xw == XW_8);
		endcase
		return ok;
	endfunction

	function automatic logic [1:0] extWords(input cam_xw_e xw);
		logic [1:0] n;
		n = 2'h0;
		if (xw == XW_16) begin
			n = 2'h1;
		end else if (xw == XW_24 || xw == XW_32) begin
			n = 2'h2;
		end
		return n;
	endfunction

	// byte: codes 0-7 upper half, 8-15 lower; word: 0-7 low half, 8-15 high
	function automatic logic [31:0] pickReg(input logic [31:0] d, input logic [3:0] code,
		input cam_size_e sz);
		logic [31:0] v;
		v = d;
		if (sz == SZ_BYTE) begin
			v = code[3] ? {24'h000000, d[7:0]} : {24'h000000, d[15:8]};
		end else if (sz == SZ_WORD) begin
			v = code[3] ? {16'h0000, d[31:16]} : {16'h0000, d[15:0]};
		end
		return v;
	endfunction

	logic [31:0] ext;
	logic [31:0] disp32;
	logic [31:0] ext16s;
	logic [31:0] step;
	logic [31:0] sum;
	logic [31:0] bitSrc;
	logic [23:0] addr;
	logic [23:0] nextPc;
	logic [23:0] pcDisp;
	logic [15:0] fw;
	cam_result_s r;

	// alignment of registers and branch targets is left to software and not checked here
	always_comb begin
		next_s = s;
		next_s.resValid = 1'b0;
		fw = s.cmd.word;
		ext = s.ext;
		if (s.cmd.xw == XW_24) begin
			ext = s.ext & TOP_MASK;
		end
		ext16s = sext16(ext[15:0]);
		disp32 = (s.cmd.xw == XW_16) ? ext16s : ext;
		step = stepOf(s.cmd.size);
		sum = 32'h00000000;
		addr = 24'h000000;
		bitSrc = pickReg(regDataB, fw[RM_LSB+:4], SZ_BYTE);
		nextPc = s.cmd.pc + INSTR_BYTES + {21'h000000, s.words, 1'b0};
		pcDisp = (s.cmd.xw == XW_8) ? sext8(fw[SHORT_LSB+:8]) : ext16s[23:0];
		r = '0;
		r.opField = fw[OP_LSB+:4];
		r.opField2 = fw[OP2_LSB+:4];
		r.firstReg = fw[RN_LSB+:4];
		r.secondReg = fw[RM_LSB+:4];
		r.illegal = !modeLegal(s.cmd.cls, s.cmd.mode) || !xwLegal(s.cmd.mode, s.cmd.xw);
		r.regWIdx = fw[RN_LSB+:3];
		unique case (s.cmd.mode)
			AM_REGDIR: begin
				r.operand = pickReg(regDataA, fw[RN_LSB+:4], s.cmd.size);
			end
			AM_REGIND: begin
				addr = regDataA[23:0];
			end
			AM_DISP: begin
				sum = regDataA + disp32;
				addr = sum[23:0];
			end
			AM_POSTINC: begin
				addr = regDataA[23:0];
				r.regWrite = 1'b1;
				r.regWData = regDataA + step;
			end
			AM_PREDEC: begin
				sum = regDataA - step;
				addr = sum[23:0];
				r.regWrite = 1'b1;
				r.regWData = sum;
			end
			AM_ABS: begin
				if (s.cmd.xw == XW_8) begin
					addr = {ABS8_FILL[23:8], fw[SHORT_LSB+:8]};
				end else if (s.cmd.xw == XW_16) begin
					addr = ext16s[23:0];
				end else begin
					addr = ext[23:0];
				end
			end
			AM_IMM: begin
				if (s.cmd.xw == XW_8) begin
					r.operand = {24'h000000, fw[SHORT_LSB+:8]};
				end else if (s.cmd.xw == XW_16) begin
					r.operand = {16'h0000, ext[15:0]};
				end else begin
					r.operand = ext;
				end
			end
			AM_IMPLICIT: begin
				r.operand = stepOf(fw[IMPL_LSB+:2]);
			end
			AM_PCREL: begin
				addr = nextPc + pcDisp;
			end
			AM_MEMIND: begin
				addr = {MEMIND_FILL[23:8], fw[SHORT_LSB+:8]};
			end
			default: begin
				r.illegal = 1'b1;
			end
		endcase
		r.eaUsed = !(s.cmd.mode inside {AM_REGDIR, AM_IMM, AM_IMPLICIT});
		r.ea = addr[15:0];
		if (s.cmd.cls == CL_JUMP || s.cmd.cls == CL_RELCALL) begin
			r.targetValid = (s.cmd.mode != AM_MEMIND);
			r.target = addr;
		end
		if (s.cmd.cls == CL_BIT) begin
			r.bitNumber = s.cmd.bitFromReg ? bitSrc[2:0] : fw[BITN_LSB+:3];
		end
		if (s.cmd.cls == CL_TRAP) begin
			r.trapVector = fw[TRAP_LSB+:2];
			r.operand = {30'h00000000, fw[TRAP_LSB+:2]};
		end
		if (r.illegal) begin
			r.regWrite = 1'b0;
			r.targetValid = 1'b0;
		end

		unique case (s.phase)
			ST_IDLE: begin
				if (cmdValid) begin
					next_s.cmd = cmd;
					next_s.ext = 32'h00000000;
					next_s.words = extWords(cmd.xw);
					next_s.left = extWords(cmd.xw);
					next_s.phase = (extWords(cmd.xw) == 2'h0) ? ST_CALC : ST_EXT;
				end
			end
			ST_EXT: begin
				if (wordValid) begin
					next_s.ext = {s.ext[15:0], word};
					next_s.left = s.left - 2'h1;
					if (s.left == 2'h1) begin
						next_s.phase = ST_CALC;
					end
				end
			end
			ST_CALC: begin
				if (!r.illegal && s.cmd.mode == AM_MEMIND) begin
					next_s.memAddr = addr[15:0];
					next_s.phase = ST_MEMRD;
				end else begin
					next_s.res = r;
					next_s.resValid = 1'b1;
					next_s.phase = ST_IDLE;
				end
			end
			// the previous result stands while the read is out; decode is rebuilt from the held command
			ST_MEMRD: begin
				if (memAck) begin
					next_s.res = r;
					next_s.res.target = memData[23:0];
					next_s.res.targetValid = 1'b1;
					next_s.resValid = 1'b1;
					next_s.phase = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign cmdReady = (s.phase == ST_IDLE);
	assign wordReady = (s.phase == ST_EXT);
	assign memReq = (s.phase == ST_MEMRD);
	assign memAddr = s.memAddr;
	assign regSelA = s.cmd.word[RN_LSB+:3];
	assign regSelB = s.cmd.word[RM_LSB+:3];
	assign resValid = s.resValid;
	assign res = s.res;
endmodule

/* hdl/cam_pkg.sv */
// shared types and constants of the address mode unit
package cam_pkg;
	typedef enum logic [2:0] {CL_ARITH, CL_XFER, CL_BIT, CL_JUMP, CL_RELCALL, CL_TRAP} cam_class_e;
	typedef enum logic [3:0] {AM_REGDIR, AM_REGIND, AM_DISP, AM_POSTINC, AM_PREDEC,
		AM_ABS, AM_IMM, AM_IMPLICIT, AM_PCREL, AM_MEMIND} cam_mode_e;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cam_size_e;
	typedef enum logic [1:0] {XW_8, XW_16, XW_24, XW_32} cam_xw_e;
	typedef enum logic [1:0] {ST_IDLE, ST_EXT, ST_CALC, ST_MEMRD} cam_phase_e;

	// field positions inside the first instruction word
	localparam int OP_LSB    = 12;
	localparam int OP2_LSB   = 8;
	localparam int RN_LSB    = 4;
	localparam int RM_LSB    = 0;
	localparam int TRAP_LSB  = 4;
	localparam int BITN_LSB  = 4;
	localparam int IMPL_LSB  = 4;
	localparam int SHORT_LSB = 0;

	localparam logic [23:0] ABS8_FILL   = 24'hffff00;
	localparam logic [23:0] MEMIND_FILL = 24'h000000;
	localparam logic [31:0] TOP_MASK    = 32'h00ffffff;
	localparam logic [31:0] STEP_BYTE   = 32'h00000001;
	localparam logic [31:0] STEP_WORD   = 32'h00000002;
	localparam logic [31:0] STEP_LONG   = 32'h00000004;
	localparam logic [23:0] INSTR_BYTES = 24'h000002;

	typedef struct packed {
		cam_class_e  cls;
		cam_mode_e   mode;
		cam_size_e   size;
		cam_xw_e     xw;
		logic        bitFromReg;
		logic [23:0] pc;
		logic [15:0] word;
	} cam_cmd_s;

	typedef struct packed {
		logic        illegal;
		logic [3:0]  opField;
		logic [3:0]  opField2;
		logic [3:0]  firstReg;
		logic [3:0]  secondReg;
		logic        eaUsed;
		logic [15:0] ea;
		logic [31:0] operand;
		logic        targetValid;
		logic [23:0] target;
		logic [2:0]  bitNumber;
		logic [1:0]  trapVector;
		logic        regWrite;
		logic [2:0]  regWIdx;
		logic [31:0] regWData;
	} cam_result_s;

	typedef struct packed {
		cam_phase_e  phase;
		cam_cmd_s    cmd;
		logic [31:0] ext;
		logic [1:0]  left;
		logic [1:0]  words;
		logic        resValid;
		cam_result_s res;
		logic [15:0] memAddr;
	} cam_state_s;

	localparam cam_state_s ST_RESET = '0;
endpackage

/* testbench/cam_unit_assertions.sv */
// port checks of the address mode unit
`timescale 1ns/1ps
module cam_unit_assertions
	import cam_pkg::*;
(
	input wire logic        sys_clk,  // clock
	input wire logic        rst_b,    // reset, active low
	input wire logic        cmdValid, // command offered
	input wire cam_cmd_s    cmd,      // command
	input wire logic        cmdReady, // idle
	input wire logic        memReq,   // read request
	input wire logic [15:0] memAddr,  // read address
	input wire logic        memAck,   // read done
	input wire logic [31:0] memData,  // read data
	input wire logic        resValid, // result pulse
	input wire cam_result_s res       // result
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence takeMode(cam_mode_e m);
		cmdValid && cmdReady && cmd.xw == XW_8 && cmd.mode == m;
	endsequence
	sequence legalDone;
		##2 resValid && !res.illegal;
	endsequence
	busy_take_a: assert property (cmdValid && cmdReady |=> !cmdReady) else $error("ready while busy");
	short_time_a: assert property (cmdValid && cmdReady && cmd.xw == XW_8 && cmd.mode != AM_MEMIND |-> ##2 resValid)
		else $error("late result");
	op_field_a: assert property (takeMode(AM_ABS) ##2 resValid |-> res.opField == $past(cmd.word[15:12], 2))
		else $error("bad op field");
	abs8_fill_a: assert property (takeMode(AM_ABS) ##0 legalDone |-> res.ea == {8'hff, $past(cmd.word[7:0], 2)})
		else $error("bad short address");
	pc_rel_a: assert property (takeMode(AM_PCREL) ##0 legalDone |-> res.target == $past(cmd.pc, 2) + 24'h2
		+ {{16{$past(cmd.word[7], 2)}}, $past(cmd.word[7:0], 2)}) else $error("bad relative target");
	mem_addr_a: assert property ($rose(memReq) |-> memAddr[15:8] == 8'h00) else $error("bad indirect address");
	mem_target_a: assert property (memReq && memAck |=> resValid && res.targetValid
		&& res.target == $past(memData[23:0])) else $error("bad indirect target");
	jump_only_a: assert property (cmdValid && cmdReady && cmd.cls != CL_JUMP |=> !memReq [*3])
		else $error("stray memory read");
	illegal_a: assert property (resValid && res.illegal |-> !res.regWrite && !res.targetValid)
		else $error("refused but acting");
endmodule

/* testbench/cam_partner.sv */
// register file and memory model beside the unit
`timescale 1ns/1ps
module cam_partner
	import cam_pkg::*;
(
	input  wire logic        sys_clk,  // clock
	input  wire logic        rst_b,    // reset, active low
	input  wire logic        slow,     // stretch memory answer
	input  wire logic [2:0]  regSelA,  // operand register
	output logic      [31:0] regDataA, // its contents
	input  wire logic [2:0]  regSelB,  // bit register
	output logic      [31:0] regDataB, // its contents
	input  wire logic        memReq,   // read request
	input  wire logic [15:0] memAddr,  // read address
	output logic             memAck,   // read done pulse
	output logic      [31:0] memData   // read data
);
	logic [3:0] waitCnt;
	// registers stay even so word and long steps keep alignment
	assign regDataA = 32'h12ff8000 + {25'h0, regSelA, 4'h0};
	assign regDataB = {29'h0, ~regSelB};
	// data is inverted outside the answer cycle
	assign memData = {16'h5a12, memAddr} ^ {32{!memAck}};
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			waitCnt <= '0;
			memAck  <= 1'b0;
		end else begin
			memAck  <= memReq && !memAck && waitCnt == (slow ? 4'h6 : 4'h0);
			waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
		end
	end
endmodule

/* testbench/test_cam_unit.sv */
// self-checking bench of the address mode unit
`timescale 1ns/1ps
module test_cam_unit
	import cam_pkg::*;
;
	localparam logic [23:0] PC0 = 24'h01fff0;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cmdValid = 1'b0;
	cam_cmd_s    cmd = '0;
	logic        wordValid = 1'b0;
	logic [15:0] word = '0;
	logic        slow = 1'b0;
	logic        fromReg = 1'b0;
	logic        cmdReady, wordReady, memReq, memAck, resValid;
	logic [2:0]  regSelA, regSelB;
	logic [31:0] regDataA, regDataB, memData;
	logic [15:0] memAddr;
	cam_result_s res;
	int          errors = 0;
	int          n_checks = 0;

	always #25 sys_clk = ~sys_clk;

	cam_unit dut (.sys_clk, .rst_b, .cmdValid, .cmd, .cmdReady, .wordValid, .word, .wordReady, .regSelA,
		.regDataA, .regSelB, .regDataB, .memReq, .memAddr, .memAck, .memData, .resValid, .res);
	cam_partner partner (.sys_clk, .rst_b, .slow, .regSelA, .regDataA, .regSelB, .regDataB, .memReq,
		.memAddr, .memAck, .memData);

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic go(input cam_class_e c, input cam_mode_e m, input cam_size_e s, input cam_xw_e x,
			input logic [15:0] w, input logic [31:0] e);
		int n;
		int k;
		n = (x == XW_8) ? 0 : (x == XW_16) ? 1 : 2;
		while (cmdReady !== 1'b1) @(negedge sys_clk);
		cmd = '{c, m, s, x, fromReg, PC0, w};
		cmdValid = 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		cmdValid = 1'b0;
		for (k = 0; k < n; k++) begin
			word = (k == n - 1) ? e[15:0] : e[31:16];
			wordValid = 1'b1;
			while (wordReady !== 1'b1) @(negedge sys_clk);
			@(posedge sys_clk);
			@(negedge sys_clk);
		end
		wordValid = 1'b0;
		for (k = 0; k < 50 && resValid !== 1'b1; k++) @(negedge sys_clk);
		chk("resValid", 1, resValid);
	endtask

	task automatic t_abs();
		go(CL_XFER, AM_ABS, SZ_BYTE, XW_8, 16'h7a5c, 0);
		chk("ea", 16'hff5c, res.ea);
		chk("eaUsed", 1, res.eaUsed);
		chk("fields", 16'h7a5c, {res.opField, res.opField2, res.firstReg, res.secondReg});
		go(CL_XFER, AM_ABS, SZ_WORD, XW_16, 16'h6b00, 32'h8123);
		chk("ea", 16'h8123, res.ea);
		go(CL_XFER, AM_ABS, SZ_WORD, XW_24, 16'h6b00, 32'hab124567);
		chk("ea", 16'h4567, res.ea);
	endtask

	task automatic t_reg();
		int i;
		go(CL_XFER, AM_REGIND, SZ_WORD, XW_8, 16'h6920, 0);
		chk("ea", 16'h8020, res.ea);
		go(CL_XFER, AM_DISP, SZ_WORD, XW_16, 16'h6e30, 32'hff00);
		chk("ea", 16'h7f30, res.ea);
		go(CL_XFER, AM_DISP, SZ_WORD, XW_24, 16'h6e30, 32'h00010000);
		chk("ea", 16'h8030, res.ea);
		for (i = 0; i < 3; i++) begin
			go(CL_XFER, AM_POSTINC, cam_size_e'(i), XW_8, 16'h6d10, 0);
			chk("ea", 16'h8010, res.ea);
			chk("wdata", 32'h12ff8010 + (1 << i), res.regWData);
			chk("regWrite", 1, res.regWrite);
			chk("regWIdx", 3'h1, res.regWIdx);
			go(CL_XFER, AM_PREDEC, cam_size_e'(i), XW_8, 16'h6d10, 0);
			chk("ea", 16'h8010 - (1 << i), res.ea);
			chk("wdata", 32'h12ff8010 - (1 << i), res.regWData);
		end
	endtask

	task automatic t_imm();
		go(CL_ARITH, AM_IMM, SZ_LONG, XW_32, 16'h7a00, 32'hdeadbeef);
		chk("operand", 32'hdeadbeef, res.operand);
		chk("eaUsed", 0, res.eaUsed);
		go(CL_ARITH, AM_IMM, SZ_LONG, XW_24, 16'h7a00, 32'hdeadbeef);
		chk("operand", 32'h00adbeef, res.operand);
		go(CL_ARITH, AM_IMPLICIT, SZ_LONG, XW_8, 16'h0a10, 0);
		chk("operand", 32'h2, res.operand);
		go(CL_ARITH, AM_REGDIR, SZ_LONG, XW_8, 16'h0a40, 0);
		chk("operand", 32'h12ff8040, res.operand);
		go(CL_ARITH, AM_REGDIR, SZ_BYTE, XW_8, 16'h0a40, 0);
		chk("operand", 8'h80, res.operand[7:0]);
	endtask

	task automatic t_misc();
		go(CL_TRAP, AM_IMPLICIT, SZ_BYTE, XW_8, 16'h5730, 0);
		chk("vector", 2'h3, res.trapVector);
		go(CL_BIT, AM_ABS, SZ_BYTE, XW_8, 16'h7d5c, 0);
		chk("bitnum", 3'h5, res.bitNumber);
		fromReg = 1'b1;
		go(CL_BIT, AM_ABS, SZ_BYTE, XW_8, 16'h7d5c, 0);
		chk("bitnum", 3'h3, res.bitNumber);
		fromReg = 1'b0;
	endtask

	task automatic t_pc();
		go(CL_RELCALL, AM_PCREL, SZ_WORD, XW_8, 16'h5580, 0);
		chk("target", 24'h01ff72, res.target);
		chk("targetValid", 1, res.targetValid);
		go(CL_RELCALL, AM_PCREL, SZ_WORD, XW_16, 16'h5500, 32'h7ffe);
		chk("target", 24'h027ff2, res.target);
		slow = 1'b1;
		go(CL_JUMP, AM_MEMIND, SZ_LONG, XW_8, 16'h5a9c, 0);
		chk("target", 24'h12009c, res.target);
		slow = 1'b0;
		go(CL_JUMP, AM_MEMIND, SZ_LONG, XW_8, 16'h5a10, 0);
		chk("target", 24'h120010, res.target);
		chk("targetValid", 1, res.targetValid);
	endtask

	task automatic t_reset();
		slow = 1'b1;
		while (cmdReady !== 1'b1) @(negedge sys_clk);
		cmd = '{CL_JUMP, AM_MEMIND, SZ_LONG, XW_8, fromReg, PC0, 16'h5a20};
		cmdValid = 1'b1;
		@(negedge sys_clk);
		cmdValid = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("memReq", 1, memReq);
		chk("memAddr", 16'h0020, memAddr);
		chk("target", 24'h120010, res.target);
		rst_b = 1'b0;
		@(negedge sys_clk);
		chk("cmdReady", 1, cmdReady);
		chk("memReq", 0, memReq);
		chk("resValid", 0, resValid);
		chk("target", 0, res.target);
		rst_b = 1'b1;
		slow = 1'b0;
		go(CL_XFER, AM_ABS, SZ_BYTE, XW_8, 16'h7a33, 0);
		chk("ea", 16'hff33, res.ea);
	endtask

	task automatic t_bad();
		cam_class_e c[5] = '{CL_ARITH, CL_XFER, CL_XFER, CL_BIT, CL_XFER};
		cam_mode_e  m[5] = '{AM_REGIND, AM_PCREL, AM_MEMIND, AM_DISP, AM_DISP};
		int i;
		for (i = 0; i < 5; i++) begin
			go(c[i], m[i], SZ_WORD, XW_8, 16'h6920, 0);
			chk("illegal", 1, res.illegal);
			chk("regWrite", 0, res.regWrite);
			chk("targetValid", 0, res.targetValid);
		end
	endtask

	task automatic end_sim();
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(negedge sys_clk);
		rst_b = 1'b1;
		t_abs();
		t_reg();
		t_imm();
		t_misc();
		t_pc();
		t_reset();
		t_bad();
		end_sim();
	end

	initial begin
		repeat (4000) @(posedge sys_clk);
		errors++;
		end_sim();
	end
endmodule

bind cam_unit cam_unit_assertions u_chk (.sys_clk, .rst_b, .cmdValid, .cmd, .cmdReady, .memReq, .memAddr,
	.memAck, .memData, .resValid, .res);
